// *** rtl/trig_seq_pkg.sv ***
package trig_seq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int TMR_W = 32;

  // event sources, shared by arm, trigger and sample levels
  typedef enum logic [2:0] {
    SRC_AUTO,
    SRC_EXT,
    SRC_HOLD,
    SRC_LEVEL,
    SRC_LINE,
    SRC_SINGLE,
    SRC_HOST,
    SRC_TIMER
  } src_t;

  typedef enum logic [1:0] {
    MODE_DC,
    MODE_DIGITIZE,
    MODE_AC_SYNC_RANDOM,
    MODE_FREQ_PERIOD
  } meas_mode_t;

  typedef enum logic [1:0] {
    LVL_ARM,
    LVL_TRIG,
    LVL_SAMPLE
  } level_t;

  localparam logic [ADDR_W-1:0] OFS_ARM = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TRIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TIMER = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;

  localparam int PRE_GENERAL = 0;
  localparam int PRE_NORMAL = 1;
  localparam int PRE_FAST = 2;
  localparam int PRE_DIGITIZE = 3;

  localparam int CFG_BUFFERING = 0;
  localparam int CFG_MODE_LSB = 1;

  localparam int ST_ARMED = 0;
  localparam int ST_TRIGGERED = 1;
  localparam int ST_READING = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_TOO_FAST = 4;
  localparam int ST_BUS_HOLD = 5;
  localparam int ST_DONE_LSB = 16;

  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0001;
  localparam logic [TMR_W-1:0] TIMER_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : trig_seq_pkg

// *** rtl/ext_edge_detect.sv ***
`timescale 1ns/1ps
module ext_edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pin_in,
  output logic fall_pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b1;
      fall_pulse <= 1'b0;
    end else if (ce) begin
      fall_pulse <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        fall_pulse <= level_q & ~s3_q;
      end
    end
  end
endmodule : ext_edge_detect

// *** rtl/interval_timer.sv ***
`timescale 1ns/1ps
module interval_timer
  import trig_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic restart,
  input wire logic run,
  input wire logic [trig_seq_pkg::TMR_W-1:0] interval,
  output logic tick
);
  logic [TMR_W-1:0] count_q;

  // first tick one cycle after restart, then one per interval
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart) begin
        count_q <= '0;
      end else if (run) begin
        if (count_q == '0) begin
          tick <= 1'b1;
          count_q <= (interval == '0) ? '0 : interval - 1'b1;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end
endmodule : interval_timer

// *** rtl/measurement_trigger_sequencer.sv ***
// Operation
// - a reading starts only after arm, then trigger, then sample events
// - an arm event arms the logic so a later trigger can be taken
// - trigger while armed enables sampling; trigger while unarmed is ignored, but a single-shot trigger stays pending until armed
// - one reading per sample event, stop at the programmed reading count
// - count setup holds readings per trigger and the sample source
// - automatic source fires at once whenever a level needs an event
// - external source fires on each falling edge of the trigger pin
// - hold suspends readings at arm or trigger; not allowed for sample
// - level source only for trigger and sample, only in dc or digitize
// - line source fires on each power-line zero crossing
// - single shot fires once on its command, then that source becomes hold
// - host source fires when output empty, memory off or empty, host asks
// - timer source spaces sample events by a programmed interval
// - timer and line rejected in ac sync or random and frequency modes
// - at power-on arm, trigger and sample sources are automatic
// - power-on, reset, normal or fast preset give count 1, sample auto
// - normal preset sets trigger to host source and arm to automatic
// - writing automatic arm or trigger source resumes held readings
// - without command buffering single shot holds the bus until readings end
// - only sub-sampling and multiple arming may break the strict ordering
// - host source counts once for arm or trigger, per request for sample
`timescale 1ns/1ps
module measurement_trigger_sequencer
  import trig_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [trig_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [trig_seq_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [trig_seq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [trig_seq_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trig_n,
  input wire logic level_cross,
  input wire logic line_zero_cross,
  input wire logic out_buf_empty,
  input wire logic mem_off_or_empty,
  input wire logic host_data_request,
  input wire logic reading_done,
  output logic reading_start,
  output logic host_bus_hold
);
  typedef enum logic [1:0] {
    SEQ_WAIT_ARM,
    SEQ_WAIT_TRIG,
    SEQ_WAIT_SAMPLE,
    SEQ_READING
  } seq_state_t;

  seq_state_t state_q;
  src_t arm_source_select_q;
  src_t trig_source_q;
  src_t sample_source_q;
  logic [CNT_W-1:0] reading_count_q;
  logic [CNT_W-1:0] done_count_q;
  logic [TMR_W-1:0] interval_q;
  logic command_buffering_q;
  meas_mode_t meas_mode_q;
  logic arm_single_q;
  logic trig_single_q;
  logic reject_q;
  logic too_fast_q;
  logic ext_fall;
  logic timer_tick;
  logic host_evt;
  logic arm_evt;
  logic trig_evt;
  logic sample_evt;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic wr_bad;
  logic [DATA_W-1:0] wr_mask;
  logic [DATA_W-1:0] wr_val;
  logic [DATA_W-1:0] status_word;
  logic last_reading;
  logic preset_any;
  logic single_cmd;
  logic reject_set;

  ext_edge_detect u_ext_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_in(ext_trig_n),
    .fall_pulse(ext_fall)
  );

  interval_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .restart(state_q == SEQ_WAIT_TRIG && trig_evt),
    .run(state_q == SEQ_WAIT_SAMPLE || state_q == SEQ_READING),
    .interval(interval_q),
    .tick(timer_tick)
  );

  // which source is allowed at which level and in which measurement mode
  function automatic logic src_allowed(input level_t lvl, input src_t src, input meas_mode_t mode);
    logic ac_or_freq;
    ac_or_freq = (mode == MODE_AC_SYNC_RANDOM) || (mode == MODE_FREQ_PERIOD);
    unique case (src)
      SRC_AUTO, SRC_EXT, SRC_HOST: src_allowed = 1'b1;
      SRC_HOLD, SRC_SINGLE: src_allowed = (lvl != LVL_SAMPLE);
      SRC_LEVEL: src_allowed = (lvl != LVL_ARM) && (mode == MODE_DC || mode == MODE_DIGITIZE);
      SRC_LINE: src_allowed = !ac_or_freq;
      SRC_TIMER: src_allowed = (lvl == LVL_SAMPLE) && !ac_or_freq;
    endcase
  endfunction : src_allowed

  // event produced by one source in the current cycle
  function automatic logic src_event(input src_t src, input logic ext, input logic lvl, input logic line,
                                     input logic host, input logic tmr);
    unique case (src)
      SRC_AUTO: src_event = 1'b1;
      SRC_EXT: src_event = ext;
      SRC_HOLD, SRC_SINGLE: src_event = 1'b0;
      SRC_LEVEL: src_event = lvl;
      SRC_LINE: src_event = line;
      SRC_HOST: src_event = host;
      SRC_TIMER: src_event = tmr;
    endcase
  endfunction : src_event

  assign host_evt = out_buf_empty & mem_off_or_empty & host_data_request;
  // pending single shot fires even though the source already reads hold
  assign arm_evt = src_event(arm_source_select_q, ext_fall, level_cross, line_zero_cross, host_evt, timer_tick)
                   | arm_single_q;
  assign trig_evt = src_event(trig_source_q, ext_fall, level_cross, line_zero_cross, host_evt, timer_tick)
                    | trig_single_q;
  assign sample_evt = src_event(sample_source_q, ext_fall, level_cross, line_zero_cross, host_evt, timer_tick);
  assign last_reading = (done_count_q + 1'b1 >= reading_count_q);

  // register bus: write address and data are taken together
  // ready stays low while frozen, or a master would see a write taken that never lands
  assign wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = ce & s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign wr_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always_comb begin
    status_word = '0;
    status_word[ST_ARMED] = (state_q != SEQ_WAIT_ARM);
    status_word[ST_TRIGGERED] = (state_q == SEQ_WAIT_SAMPLE) || (state_q == SEQ_READING);
    status_word[ST_READING] = (state_q == SEQ_READING);
    status_word[ST_REJECT] = reject_q;
    status_word[ST_TOO_FAST] = too_fast_q;
    status_word[ST_BUS_HOLD] = host_bus_hold;
    status_word[ST_DONE_LSB +: CNT_W] = done_count_q;
  end

  function automatic logic [DATA_W-1:0] reg_value(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] stat,
                                                 input src_t arm, input src_t trig, input src_t smp,
                                                 input logic [CNT_W-1:0] cnt, input logic [TMR_W-1:0] tmr,
                                                 input logic buf_en, input meas_mode_t mode);
    reg_value = '0;
    case (addr)
      OFS_ARM: reg_value[2:0] = arm;
      OFS_TRIG: reg_value[2:0] = trig;
      OFS_COUNT: reg_value[CNT_W-1:0] = cnt;
      OFS_SAMPLE: reg_value[2:0] = smp;
      OFS_TIMER: reg_value = tmr;
      OFS_CONFIG: begin
        reg_value[CFG_BUFFERING] = buf_en;
        reg_value[CFG_MODE_LSB +: 2] = mode;
      end
      OFS_STATUS: reg_value = stat;
      default: reg_value = '0;
    endcase
  endfunction : reg_value

  always_comb begin
    unique case (s_axi_awaddr)
      OFS_ARM, OFS_TRIG, OFS_COUNT, OFS_SAMPLE, OFS_TIMER, OFS_PRESET, OFS_CONFIG, OFS_STATUS: wr_bad = 1'b0;
      default: wr_bad = 1'b1;
    endcase
  end

  assign wr_hit = wr_go & ~wr_bad;
  assign wr_val = (reg_value(s_axi_awaddr, status_word, arm_source_select_q, trig_source_q, sample_source_q,
                             reading_count_q, interval_q, command_buffering_q, meas_mode_q) & ~wr_mask)
                  | (s_axi_wdata & wr_mask);
  assign preset_any = wr_hit && (s_axi_awaddr == OFS_PRESET) && (wr_val[3:0] != '0);
  assign single_cmd = wr_hit && src_t'(wr_val[2:0]) == SRC_SINGLE
                      && (s_axi_awaddr == OFS_ARM || s_axi_awaddr == OFS_TRIG);

  always_comb begin
    reject_set = 1'b0;
    if (wr_hit) begin
      unique case (s_axi_awaddr)
        OFS_ARM: reject_set = !src_allowed(LVL_ARM, src_t'(wr_val[2:0]), meas_mode_q);
        OFS_TRIG: reject_set = !src_allowed(LVL_TRIG, src_t'(wr_val[2:0]), meas_mode_q);
        OFS_SAMPLE: reject_set = !src_allowed(LVL_SAMPLE, src_t'(wr_val[2:0]), meas_mode_q);
        default: reject_set = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_value(s_axi_araddr, status_word, arm_source_select_q, trig_source_q,
                                 sample_source_q, reading_count_q, interval_q, command_buffering_q, meas_mode_q);
        unique case (s_axi_araddr)
          OFS_ARM, OFS_TRIG, OFS_COUNT, OFS_SAMPLE, OFS_TIMER, OFS_PRESET, OFS_CONFIG, OFS_STATUS:
            s_axi_rresp <= RESP_OKAY;
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // source selection, presets and single-shot takeover
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_source_select_q <= SRC_AUTO;
      trig_source_q <= SRC_AUTO;
      sample_source_q <= SRC_AUTO;
      reading_count_q <= COUNT_RESET;
    end else if (ce && wr_hit) begin
      unique case (s_axi_awaddr)
        OFS_PRESET: begin
          if (wr_val[PRE_GENERAL] || wr_val[PRE_NORMAL] || wr_val[PRE_FAST]) begin
            reading_count_q <= COUNT_RESET;
            sample_source_q <= SRC_AUTO;
          end
          if (wr_val[PRE_GENERAL]) begin
            arm_source_select_q <= SRC_AUTO;
            trig_source_q <= SRC_AUTO;
          end else if (wr_val[PRE_NORMAL]) begin
            arm_source_select_q <= SRC_AUTO;
            trig_source_q <= SRC_HOST;
          end else if (wr_val[PRE_FAST] || wr_val[PRE_DIGITIZE]) begin
            arm_source_select_q <= SRC_HOLD;
          end
        end
        // an illegal source is refused and the old one kept
        OFS_ARM: if (!reject_set) begin
          arm_source_select_q <= (src_t'(wr_val[2:0]) == SRC_SINGLE) ? SRC_HOLD : src_t'(wr_val[2:0]);
        end
        OFS_TRIG: if (!reject_set) begin
          trig_source_q <= (src_t'(wr_val[2:0]) == SRC_SINGLE) ? SRC_HOLD : src_t'(wr_val[2:0]);
        end
        OFS_SAMPLE: if (!reject_set) begin
          sample_source_q <= src_t'(wr_val[2:0]);
        end
        OFS_COUNT: reading_count_q <= wr_val[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interval_q <= TIMER_RESET;
      command_buffering_q <= 1'b0;
      meas_mode_q <= MODE_DC;
    end else if (ce && wr_hit) begin
      if (s_axi_awaddr == OFS_TIMER) begin
        interval_q <= wr_val;
      end
      if (s_axi_awaddr == OFS_CONFIG) begin
        command_buffering_q <= wr_val[CFG_BUFFERING];
        meas_mode_q <= meas_mode_t'(wr_val[CFG_MODE_LSB +: 2]);
      end
    end
  end

  // pending single shots, consumed when their level takes the event
  always_ff @(posedge aclk) begin
    if (!aresetn || preset_any) begin
      arm_single_q <= 1'b0;
      trig_single_q <= 1'b0;
    end else if (ce) begin
      if (single_cmd && s_axi_awaddr == OFS_ARM) begin
        arm_single_q <= 1'b1;
      end else if (state_q == SEQ_WAIT_ARM) begin
        arm_single_q <= 1'b0;
      end
      if (single_cmd && s_axi_awaddr == OFS_TRIG) begin
        trig_single_q <= 1'b1;
      end else if (state_q == SEQ_WAIT_TRIG && trig_evt) begin
        trig_single_q <= 1'b0;
      end
    end
  end

  // sticky errors: write one to clear, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reject_q <= 1'b0;
      too_fast_q <= 1'b0;
    end else if (ce) begin
      if (reject_set) begin
        reject_q <= 1'b1;
      end else if (wr_hit && s_axi_awaddr == OFS_STATUS && wr_val[ST_REJECT]) begin
        reject_q <= 1'b0;
      end
      if (state_q == SEQ_READING && timer_tick && sample_source_q == SRC_TIMER) begin
        too_fast_q <= 1'b1;
      end else if (wr_hit && s_axi_awaddr == OFS_STATUS && wr_val[ST_TOO_FAST]) begin
        too_fast_q <= 1'b0;
      end
    end
  end

  // strict arm, trigger, sample order; no sub-sampling or multiple arming here
  always_ff @(posedge aclk) begin
    if (!aresetn || preset_any) begin
      state_q <= SEQ_WAIT_ARM;
      done_count_q <= '0;
      reading_start <= 1'b0;
    end else if (ce) begin
      reading_start <= 1'b0;
      unique case (state_q)
        SEQ_WAIT_ARM: if (arm_evt) begin
          state_q <= SEQ_WAIT_TRIG;
        end
        SEQ_WAIT_TRIG: if (trig_evt) begin
          state_q <= SEQ_WAIT_SAMPLE;
          done_count_q <= '0;
        end
        // host requests only count as samples from here, so one request fires a trigger once
        SEQ_WAIT_SAMPLE: if (sample_evt) begin
          state_q <= SEQ_READING;
          reading_start <= 1'b1;
        end
        SEQ_READING: if (reading_done) begin
          done_count_q <= done_count_q + 1'b1;
          state_q <= last_reading ? SEQ_WAIT_ARM : SEQ_WAIT_SAMPLE;
        end
      endcase
    end
  end

  // bus stays busy for the whole single-shot group when commands are unbuffered
  always_ff @(posedge aclk) begin
    if (!aresetn || preset_any) begin
      host_bus_hold <= 1'b0;
    end else if (ce) begin
      if (single_cmd && !command_buffering_q) begin
        host_bus_hold <= 1'b1;
      end else if (state_q == SEQ_READING && reading_done && last_reading) begin
        host_bus_hold <= 1'b0;
      end
    end
  end
endmodule : measurement_trigger_sequencer

// *** testbench/trig_seq_chk.sv ***
`timescale 1ns/1ps
module trig_seq_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic reading_done,
  input wire logic reading_start,
  input wire logic host_bus_hold
);
  logic busy_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && ce;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_rvalid && ce;
  endsequence
  // a reading is open from its start pulse until the engine reports it done
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_q <= 1'h0;
    else if (reading_start) busy_q <= 1'h1;
    else if (reading_done) busy_q <= 1'h0;
  end
  wr_answer_a: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  rd_answer_a: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  start_pulse_a: assert property (reading_start |=> !reading_start)
    else $error("start pulse longer than one cycle");
  one_per_read_a: assert property (reading_start |-> !busy_q)
    else $error("reading started before previous ended");
  hold_release_a: assert property ($fell(host_bus_hold) |-> $past(reading_done || (s_axi_awvalid && s_axi_wvalid)))
    else $error("bus hold released without cause");
endmodule : trig_seq_chk

bind measurement_trigger_sequencer trig_seq_chk u_trig_seq_chk (.*);

// *** testbench/meas_engine_model.sv ***
`timescale 1ns/1ps
module meas_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reading_start,
  input wire logic [7:0] dly,
  output logic reading_done
);
  logic [7:0] cnt_q;
  logic busy_q;
  // done comes only for a started reading, after dly cycles
  always @(posedge aclk) begin
    reading_done <= 1'h0;
    if (!aresetn) busy_q <= 1'h0;
    else if (reading_start) begin
      busy_q <= 1'h1;
      cnt_q <= dly;
    end else if (busy_q) begin
      if (cnt_q <= 8'h1) begin
        reading_done <= 1'h1;
        busy_q <= 1'h0;
      end else cnt_q <= cnt_q - 8'h1;
    end
  end
endmodule : meas_engine_model

// *** testbench/measurement_trigger_sequencer_tb.sv ***
`timescale 1ns/1ps
module measurement_trigger_sequencer_tb;
  import trig_seq_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic ext_trig_n = 1'h1, level_cross = 1'h0, line_zero_cross = 1'h0;
  logic out_buf_empty = 1'h1, mem_off_or_empty = 1'h1, host_data_request = 1'h0;
  logic reading_done, reading_start, host_bus_hold;
  logic [7:0] dly = 8'h02;
  int mismatches = 0, checks_done = 0, nrd = 0, cyc = 0, last = 0, gap = 0, n0;
  int srcs[4] = '{1, 3, 4, 6};

  measurement_trigger_sequencer u_measurement_trigger_sequencer (.*);
  meas_engine_model u_meas_engine_model (.*);

  always #10 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (reading_start === 1'h1) begin
      nrd <= nrd + 1;
      last <= cyc;
      gap <= cyc - last;
    end
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(rv, e);
  endtask : rdc

  // the pin is held low for several cycles so the synchroniser sees it settle
  task fire(input int s);
    @(posedge aclk);
    case (s)
      1: ext_trig_n <= 1'h0;
      3: level_cross <= 1'h1;
      4: line_zero_cross <= 1'h1;
      default: host_data_request <= 1'h1;
    endcase
    repeat (s == 1 ? 4 : 1) @(posedge aclk);
    ext_trig_n <= 1'h1;
    level_cross <= 1'h0;
    line_zero_cross <= 1'h0;
    host_data_request <= 1'h0;
    repeat (20) @(posedge aclk);
  endtask : fire

  task expect_rd(input int e);
    repeat (60) @(posedge aclk);
    cmp(nrd - n0, e);
  endtask : expect_rd

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(OFS_ARM, 0);
    rdc(OFS_TRIG, 0);
    rdc(OFS_SAMPLE, 0);
    rdc(OFS_COUNT, 1);
    n0 = nrd;
    repeat (60) @(posedge aclk);
    cmp(nrd - n0 > 3, 1);
    wr(OFS_ARM, 2);
    repeat (20) @(posedge aclk);
    n0 = nrd;
    expect_rd(0);
    wr(OFS_ARM, 0);
    repeat (40) @(posedge aclk);
    cmp(nrd > n0, 1);
    wr(OFS_SAMPLE, 2);
    rdc(OFS_SAMPLE, 0);
    rd(OFS_STATUS);
    cmp(rv[ST_REJECT], 1);
    wr(OFS_ARM, 3);
    rdc(OFS_ARM, 0);
    wr(OFS_CONFIG, 4);
    wr(OFS_SAMPLE, 7);
    rdc(OFS_SAMPLE, 0);
    wr(OFS_TRIG, 4);
    rdc(OFS_TRIG, 0);
    wr(OFS_CONFIG, 0);
    rd(8'h40);
    cmp(rr, RESP_SLVERR);
    wr(OFS_COUNT, 5);
    wr(OFS_PRESET, 2);
    rdc(OFS_TRIG, 6);
    rdc(OFS_ARM, 0);
    rdc(OFS_COUNT, 1);
    wr(OFS_COUNT, 3);
    out_buf_empty <= 1'h0;
    host_data_request <= 1'h1;
    n0 = nrd;
    expect_rd(0);
    out_buf_empty <= 1'h1;
    repeat (8) @(posedge aclk);
    host_data_request <= 1'h0;
    repeat (20) @(posedge aclk);
    expect_rd(3);
    wr(OFS_TRIG, 1);
    n0 = nrd;
    fire(1);
    expect_rd(3);
    wr(OFS_TRIG, 2);
    wr(OFS_COUNT, 2);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SAMPLE, srcs[i]);
      n0 = nrd;
      wr(OFS_TRIG, 5);
      @(posedge aclk);
      cmp(host_bus_hold, 1);
      repeat (3) fire(srcs[i]);
      expect_rd(2);
      cmp(host_bus_hold, 0);
      rdc(OFS_TRIG, 2);
    end
    dly <= 8'h09;
    wr(OFS_SAMPLE, 7);
    wr(OFS_TIMER, 20);
    n0 = nrd;
    wr(OFS_TRIG, 5);
    expect_rd(2);
    cmp(gap, 20);
    wr(OFS_TIMER, 2);
    wr(OFS_TRIG, 5);
    repeat (60) @(posedge aclk);
    rd(OFS_STATUS);
    cmp(rv[ST_TOO_FAST], 1);
    wr(OFS_PRESET, 4);
    rdc(OFS_ARM, 2);
    rdc(OFS_COUNT, 1);
    rdc(OFS_SAMPLE, 0);
    results();
  end
endmodule : measurement_trigger_sequencer_tb
